// >>> logic/brx_regs.svh
// Register offsets, field positions, reset values and constants for brx
`ifndef BRX_REGS_SVH
`define BRX_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BRX_OFF_LC 8'h00
`define BRX_OFF_EC 8'h08
`define BRX_OFF_CFM 8'h10
`define BRX_OFF_PFS 8'h18
`define BRX_OFF_PSR 8'h20
`define BRX_OFF_CSD_BASE 8'h28
`define BRX_OFF_CSD_LIMIT 8'h30
`define BRX_OFF_CSD_ATTR 8'h38
`define BRX_OFF_STATUS 8'h40

// ****************************************
// Field positions
// ****************************************
`define BRX_LOWER_PRIV_TRAP_ENABLE 0
`define BRX_INSTRUCTION_SET_STATUS_BIT 1
`define BRX_PSR_CPL_LO 2
`define BRX_PSR_CPL_HI 3
`define BRX_ATTR_DPL_LO 0
`define BRX_ATTR_DPL_HI 1
`define BRX_ATTR_BIG 2
`define BRX_ATTR_INTERCEPT 3
`define BRX_PFS_PFM_HI 37
`define BRX_PFS_PEC_LO 52
`define BRX_PFS_PEC_HI 57
`define BRX_PFS_PPL_LO 62
`define BRX_PFS_PPL_HI 63

// ****************************************
// Reset values
// ****************************************
`define BRX_RST_LC 64'h0
`define BRX_RST_EC 6'h0
`define BRX_RST_CFM 38'h0
`define BRX_RST_PFS 64'h0
`define BRX_RST_CPL 2'h0
`define BRX_RST_CSD_BASE 32'h0
`define BRX_RST_CSD_LIMIT 32'hffff_ffff
`define BRX_RST_CSD_ATTR 4'h4

// ****************************************
// Constants
// ****************************************
`define BRX_BUNDLE_BYTES 64'h10
`define BRX_BUNDLE_MASK 64'hffff_ffff_ffff_fff0
`define BRX_LOOP_SLOT 2'h2
`define BRX_SEG16_MAX 32'h0000_ffff

`endif

// >>> logic/brx_pkg.sv
// Types shared by the branch resolution unit
package brx_pkg;

    typedef enum logic [3:0] {
        BT_COND,
        BT_CALL,
        BT_RET,
        BT_IA,
        BT_CLOOP,
        BT_CTOP,
        BT_CEXIT,
        BT_WTOP,
        BT_WEXIT
    } brx_btype_t;

    typedef enum logic [1:0] {
        WH_SPTK,
        WH_SPNT,
        WH_DPTK,
        WH_DPNT
    } brx_whether_t;

    typedef struct packed {
        logic [5:0] rrb_pr;
        logic [6:0] rrb_fr;
        logic [6:0] rrb_gr;
        logic [3:0] sor;
        logic [6:0] sol;
        logic [6:0] sof;
    } brx_cfm_t;

    typedef struct packed {
        logic valid;
        brx_btype_t btype;
        logic ip_rel;
        logic qp_zero;
        logic qualifying_predicate;
        logic [1:0] slot;
        logic [63:0] ip;
        logic [20:0] bundle_displacement_field;
        logic [63:0] b2;
        brx_whether_t whether;
        logic prefetch_hint_field;
        logic dealloc_hint_field;
    } brx_req_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [63:0] target;
        logic link_we;
        logic [63:0] link;
        logic illegal_fault;
        logic lp_trap;
        logic general_protection_fault;
        logic ia_intercept;
        logic alat_ignore;
        logic isa_switch;
        logic prefetch_hint_field;
        logic dealloc_hint_field;
    } brx_res_t;

endpackage : brx_pkg

// >>> logic/brx_unit.sv
// Branch resolution unit: decode, condition, target and frame effects
//
// The register offsets and the plain strobed port were chosen for this implementation.
module brx_unit (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Branch issue
    input wire brx_pkg::brx_req_t BR_REQ_I,
    input wire logic GROUP_DONE_I,
    input wire logic DIRTY_REGS_I,
    input wire logic FIRST_LEGACY_DONE_I,
    // Branch result
    output brx_pkg::brx_res_t BR_RES_O,
    output logic BR_BUSY_O,
    output logic RF_HOLD_O,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [63:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [63:0] REG_RDATA_O
);
    import brx_pkg::*;
    `include "brx_regs.svh"

    typedef enum logic {ST_IDLE, ST_WAIT} brx_state_t;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic is_loop(input brx_btype_t t);
        is_loop = (t == BT_CLOOP) || (t == BT_CTOP) || (t == BT_CEXIT) ||
                  (t == BT_WTOP) || (t == BT_WEXIT);
    endfunction : is_loop

    function automatic logic [63:0] rel_target(input logic [63:0] ip,
                                               input logic [20:0] d);
        logic [63:0] off;
        off = {{39{d[20]}}, d, 4'h0};
        rel_target = ip + off;
    endfunction : rel_target

    // ****************************************
    // State
    // ****************************************
    brx_state_t st, next_st;
    brx_req_t held, next_held;
    logic [63:0] loop_count_register, next_loop_count_register;
    logic [5:0] epilog_counter, next_epilog_counter;
    brx_cfm_t current_frame_marker, next_current_frame_marker;
    logic [63:0] pfs, next_pfs;
    logic [1:0] cpl, next_cpl;
    logic lower_priv_trap_enable, next_lower_priv_trap_enable;
    logic instruction_set_status_bit, next_instruction_set_status_bit;
    logic [31:0] csd_base, next_csd_base;
    logic [31:0] csd_limit, next_csd_limit;
    logic [3:0] csd_attr, next_csd_attr;
    logic rf_hold, next_rf_hold;
    logic last_taken, next_last_taken;
    logic last_fault, next_last_fault;
    brx_res_t res, next_res;
    logic busy, next_busy;
    logic [63:0] rdata, next_rdata;

    // ****************************************
    // Resolution
    // ****************************************
    brx_req_t act;
    logic go;
    logic cond;
    logic illegal;
    logic [63:0] tgt;
    logic [31:0] legacy_instruction_pointer;
    logic [1:0] ppl;
    logic lowered;

    always_comb begin
        act = (st == ST_WAIT) ? held : BR_REQ_I;
        // Waits for earlier group work so its effects are seen
        go = act.valid && GROUP_DONE_I &&
             ((st == ST_WAIT) || BR_REQ_I.valid);
        next_st = st;
        next_held = held;
        next_busy = 1'b0;
        if (st == ST_IDLE && BR_REQ_I.valid && !GROUP_DONE_I) begin
            next_st = ST_WAIT;
            next_held = BR_REQ_I;
            next_busy = 1'b1;
        end else if (st == ST_WAIT && !GROUP_DONE_I) begin
            next_busy = 1'b1;
        end else if (st == ST_WAIT) begin
            next_st = ST_IDLE;
        end

        // Register writes first; a resolving branch overrides below
        next_loop_count_register = loop_count_register;
        next_epilog_counter = epilog_counter;
        next_current_frame_marker = current_frame_marker;
        next_pfs = pfs;
        next_cpl = cpl;
        next_lower_priv_trap_enable = lower_priv_trap_enable;
        next_instruction_set_status_bit = instruction_set_status_bit;
        next_csd_base = csd_base;
        next_csd_limit = csd_limit;
        next_csd_attr = csd_attr;
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `BRX_OFF_LC: next_loop_count_register = REG_WDATA_I;
                `BRX_OFF_EC: next_epilog_counter = REG_WDATA_I[5:0];
                `BRX_OFF_CFM: next_current_frame_marker = REG_WDATA_I[37:0];
                `BRX_OFF_PFS: next_pfs = REG_WDATA_I;
                `BRX_OFF_PSR: begin
                    next_lower_priv_trap_enable = REG_WDATA_I[`BRX_LOWER_PRIV_TRAP_ENABLE];
                    next_instruction_set_status_bit = REG_WDATA_I[`BRX_INSTRUCTION_SET_STATUS_BIT];
                    next_cpl = REG_WDATA_I[`BRX_PSR_CPL_HI:`BRX_PSR_CPL_LO];
                end
                `BRX_OFF_CSD_BASE: next_csd_base = REG_WDATA_I[31:0];
                `BRX_OFF_CSD_LIMIT: next_csd_limit = REG_WDATA_I[31:0];
                `BRX_OFF_CSD_ATTR: next_csd_attr = REG_WDATA_I[3:0];
                default: ;
            endcase
        end

        // Target: IP-relative or indirect
        tgt = act.ip_rel ? rel_target(act.ip, act.bundle_displacement_field)
                         : act.b2;
        legacy_instruction_pointer = act.b2[31:0] - csd_base;
        ppl = pfs[`BRX_PFS_PPL_HI:`BRX_PFS_PPL_LO];
        // Larger level number means less privilege
        lowered = ppl > cpl;
        cond = 1'b0;
        illegal = 1'b0;
        next_res = '0;
        next_res.valid = go;
        next_res.prefetch_hint_field = act.prefetch_hint_field;
        next_res.dealloc_hint_field = act.dealloc_hint_field;
        next_rf_hold = rf_hold && !FIRST_LEGACY_DONE_I;
        next_last_taken = last_taken;
        next_last_fault = last_fault;

        if (go) begin
            // Pseudo-ops arrive as cond with predicate 0 reading 1
            if (is_loop(act.btype) && act.slot != `BRX_LOOP_SLOT) begin
                illegal = 1'b1;
            end else begin
                unique case (act.btype)
                    BT_COND: cond = act.qualifying_predicate;
                    BT_CALL: begin
                        cond = act.qualifying_predicate;
                        if (cond) begin
                            next_pfs = '0;
                            next_pfs[`BRX_PFS_PFM_HI:0] =
                                current_frame_marker;
                            next_pfs[`BRX_PFS_PEC_HI:`BRX_PFS_PEC_LO] =
                                epilog_counter;
                            next_pfs[`BRX_PFS_PPL_HI:`BRX_PFS_PPL_LO] =
                                cpl;
                            // Callee sees only the caller outputs
                            next_current_frame_marker = '0;
                            next_current_frame_marker.sof =
                                current_frame_marker.sof -
                                current_frame_marker.sol;
                            next_res.link_we = 1'b1;
                            next_res.link = (act.ip & `BRX_BUNDLE_MASK) +
                                            `BRX_BUNDLE_BYTES;
                        end
                    end
                    BT_RET: begin
                        cond = act.qualifying_predicate;
                        if (cond) begin
                            next_current_frame_marker =
                                pfs[`BRX_PFS_PFM_HI:0];
                            next_epilog_counter =
                                pfs[`BRX_PFS_PEC_HI:`BRX_PFS_PEC_LO];
                            if (ppl >= cpl) begin
                                next_cpl = ppl;
                            end
                            next_res.lp_trap = lowered &&
                                               lower_priv_trap_enable;
                        end
                    end
                    BT_IA: begin
                        if (!act.qp_zero || DIRTY_REGS_I) begin
                            illegal = 1'b1;
                        end else if (csd_attr[`BRX_ATTR_INTERCEPT]) begin
                            next_res.ia_intercept = 1'b1;
                        end else begin
                            cond = 1'b1;
                            // Bank and privilege untouched here
                            next_instruction_set_status_bit = 1'b1;
                            next_res.isa_switch = 1'b1;
                            next_current_frame_marker = '0;
                            next_res.alat_ignore = 1'b1;
                            next_rf_hold = 1'b1;
                            next_res.general_protection_fault =
                                (legacy_instruction_pointer > csd_limit) ||
                                (cpl > csd_attr[`BRX_ATTR_DPL_HI:
                                                `BRX_ATTR_DPL_LO]) ||
                                (!csd_attr[`BRX_ATTR_BIG] &&
                                 legacy_instruction_pointer > `BRX_SEG16_MAX);
                        end
                    end
                    BT_CLOOP: begin
                        // Predicate plays no part
                        cond = loop_count_register != 64'h0;
                        if (cond) begin
                            next_loop_count_register =
                                loop_count_register - 64'h1;
                        end
                    end
                    BT_CTOP, BT_CEXIT: begin
                        cond = (loop_count_register != 64'h0) ||
                               (epilog_counter > 6'h01);
                        if (loop_count_register != 64'h0) begin
                            next_loop_count_register =
                                loop_count_register - 64'h1;
                        end else if (epilog_counter != 6'h00) begin
                            next_epilog_counter =
                                epilog_counter - 6'h01;
                        end
                        if (act.btype == BT_CEXIT) begin
                            // EC counts down while draining and stops at zero
                            cond = !cond;
                        end
                    end
                    BT_WTOP, BT_WEXIT: begin
                        cond = act.qualifying_predicate ||
                               (epilog_counter > 6'h01);
                        if (!act.qualifying_predicate &&
                            epilog_counter != 6'h00) begin
                            next_epilog_counter =
                                epilog_counter - 6'h01;
                        end
                        if (act.btype == BT_WEXIT) begin
                            cond = !cond;
                        end
                    end
                    default: illegal = 1'b1;
                endcase
            end
            next_res.illegal_fault = illegal;
            next_res.taken = cond && !illegal;
            if (act.btype == BT_IA) begin
                next_res.target = {32'h0, legacy_instruction_pointer};
            end else begin
                next_res.target = tgt & `BRX_BUNDLE_MASK;
            end
            next_last_taken = cond && !illegal;
            next_last_fault = illegal;
        end

        // Register read, data one cycle later
        next_rdata = 64'h0;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `BRX_OFF_LC: next_rdata = loop_count_register;
                `BRX_OFF_EC: next_rdata = {58'h0, epilog_counter};
                `BRX_OFF_CFM: next_rdata = {26'h0, current_frame_marker};
                `BRX_OFF_PFS: next_rdata = pfs;
                `BRX_OFF_PSR: next_rdata = {60'h0, cpl,
                                            instruction_set_status_bit,
                                            lower_priv_trap_enable};
                `BRX_OFF_CSD_BASE: next_rdata = {32'h0, csd_base};
                `BRX_OFF_CSD_LIMIT: next_rdata = {32'h0, csd_limit};
                `BRX_OFF_CSD_ATTR: next_rdata = {60'h0, csd_attr};
                `BRX_OFF_STATUS: next_rdata = {60'h0, rf_hold, busy,
                                               last_fault, last_taken};
                default: next_rdata = 64'h0;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st <= ST_IDLE;
            held <= '0;
            loop_count_register <= `BRX_RST_LC;
            epilog_counter <= `BRX_RST_EC;
            current_frame_marker <= `BRX_RST_CFM;
            pfs <= `BRX_RST_PFS;
            cpl <= `BRX_RST_CPL;
            lower_priv_trap_enable <= 1'b0;
            instruction_set_status_bit <= 1'b0;
            csd_base <= `BRX_RST_CSD_BASE;
            csd_limit <= `BRX_RST_CSD_LIMIT;
            csd_attr <= `BRX_RST_CSD_ATTR;
            rf_hold <= 1'b0;
            last_taken <= 1'b0;
            last_fault <= 1'b0;
            res <= '0;
            busy <= 1'b0;
            rdata <= 64'h0;
        end else begin
            st <= next_st;
            held <= next_held;
            loop_count_register <= next_loop_count_register;
            epilog_counter <= next_epilog_counter;
            current_frame_marker <= next_current_frame_marker;
            pfs <= next_pfs;
            cpl <= next_cpl;
            lower_priv_trap_enable <= next_lower_priv_trap_enable;
            instruction_set_status_bit <= next_instruction_set_status_bit;
            csd_base <= next_csd_base;
            csd_limit <= next_csd_limit;
            csd_attr <= next_csd_attr;
            rf_hold <= next_rf_hold;
            last_taken <= next_last_taken;
            last_fault <= next_last_fault;
            res <= next_res;
            busy <= next_busy;
            rdata <= next_rdata;
        end
    end

    assign BR_RES_O = res;
    assign BR_BUSY_O = busy;
    assign RF_HOLD_O = rf_hold;
    assign REG_RDATA_O = rdata;

endmodule : brx_unit

// >>> bench/brx_unit_sva.sv
// Port-level assertions for the branch resolution unit
module brx_unit_sva (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Branch side
    input wire brx_pkg::brx_req_t BR_REQ_I,
    input wire logic GROUP_DONE_I,
    input wire logic FIRST_LEGACY_DONE_I,
    input wire brx_pkg::brx_res_t BR_RES_O,
    input wire logic BR_BUSY_O,
    input wire logic RF_HOLD_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import brx_pkg::*;
    // ****************************************
    // Helpers
    // ****************************************
    wire issue = BR_REQ_I.valid && GROUP_DONE_I && !BR_BUSY_O;
    wire [20:0] disp = BR_REQ_I.bundle_displacement_field;
    wire [63:0] off = {{39{disp[20]}}, disp, 4'h0};
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    // ****************************************
    // Assertions
    // ****************************************
    a_resolve_next: assert property (
        issue |=> BR_RES_O.valid) else $error("No result after issue");
    a_wait_group: assert property (
        BR_REQ_I.valid && !GROUP_DONE_I && !BR_BUSY_O |=>
        BR_BUSY_O && !BR_RES_O.valid) else $error("Early resolve");
    a_no_stray: assert property (
        !issue && !(BR_BUSY_O && GROUP_DONE_I) |=> !BR_RES_O.valid)
        else $error("Result without request");
    a_cond_taken: assert property (
        issue && BR_REQ_I.btype == BT_COND |=>
        BR_RES_O.taken == $past(BR_REQ_I.qualifying_predicate))
        else $error("Cond taken mismatch");
    a_iprel_target: assert property (
        issue && BR_REQ_I.btype == BT_COND && BR_REQ_I.ip_rel &&
        BR_REQ_I.qualifying_predicate |=>
        BR_RES_O.target == (($past(BR_REQ_I.ip) + $past(off)) & ~64'hf))
        else $error("Relative target wrong");
    a_bundle_align: assert property (
        BR_RES_O.valid && BR_RES_O.taken && !BR_RES_O.isa_switch |->
        BR_RES_O.target[3:0] == 4'h0) else $error("Target not slot 0");
    a_ia_pred: assert property (
        issue && BR_REQ_I.btype == BT_IA && !BR_REQ_I.qp_zero |=>
        BR_RES_O.illegal_fault && !BR_RES_O.taken)
        else $error("Predicated switch not refused");
    a_loop_slot: assert property (
        issue && BR_REQ_I.slot != 2'h2 && BR_REQ_I.btype inside
        {BT_CLOOP, BT_CTOP, BT_CEXIT, BT_WTOP, BT_WEXIT} |=>
        BR_RES_O.illegal_fault && !BR_RES_O.taken)
        else $error("Loop branch slot fault missing");
    a_call_link: assert property (
        issue && BR_REQ_I.btype == BT_CALL && BR_REQ_I.qualifying_predicate
        |=> BR_RES_O.link_we &&
        BR_RES_O.link == ($past(BR_REQ_I.ip) & ~64'hf) + 64'h10)
        else $error("Call link wrong");
    a_rf_hold: assert property (
        RF_HOLD_O && !FIRST_LEGACY_DONE_I |=> RF_HOLD_O)
        else $error("Resume hold dropped early");
    c_call: cover property (issue && BR_REQ_I.btype == BT_CALL);
    c_wait: cover property (BR_BUSY_O && GROUP_DONE_I);
    c_switch: cover property (BR_RES_O.valid && BR_RES_O.isa_switch);
endmodule : brx_unit_sva

bind brx_unit brx_unit_sva u_brx_unit_sva (.CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I), .BR_REQ_I(BR_REQ_I), .GROUP_DONE_I(GROUP_DONE_I),
    .FIRST_LEGACY_DONE_I(FIRST_LEGACY_DONE_I), .BR_RES_O(BR_RES_O),
    .BR_BUSY_O(BR_BUSY_O), .RF_HOLD_O(RF_HOLD_O));

// >>> bench/testbench.sv
// Directed testbench for the branch resolution unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import brx_pkg::*;
    logic CLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    brx_req_t BR_REQ_I = '0;
    logic GROUP_DONE_I = 1'b1;
    logic DIRTY_REGS_I = 1'b0;
    logic FIRST_LEGACY_DONE_I = 1'b0;
    brx_res_t BR_RES_O;
    logic BR_BUSY_O;
    logic RF_HOLD_O;
    logic [7:0] REG_ADDR_I = 8'h00;
    logic [63:0] REG_WDATA_I = 64'h0;
    logic REG_WR_I = 1'b0;
    logic REG_RD_I = 1'b0;
    logic [63:0] REG_RDATA_O;
    int failures = 0;
    int checked = 0;
    brx_res_t res;
    brx_req_t r;
    logic [37:0] cfm0 = {6'h1, 7'h2, 7'h3, 4'h0, 7'h4, 7'ha};

    always #10 CLK_I = ~CLK_I;

    brx_unit u_brx_unit (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
        .BR_REQ_I(BR_REQ_I), .GROUP_DONE_I(GROUP_DONE_I),
        .DIRTY_REGS_I(DIRTY_REGS_I), .FIRST_LEGACY_DONE_I(FIRST_LEGACY_DONE_I),
        .BR_RES_O(BR_RES_O), .BR_BUSY_O(BR_BUSY_O), .RF_HOLD_O(RF_HOLD_O),
        .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
        .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [63:0] e);
        @(posedge CLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1 chk(REG_RDATA_O, e);
    endtask : rd

    function automatic brx_req_t mk(brx_btype_t t, logic q, logic [1:0] s,
                                    logic [20:0] d, logic [63:0] b);
        mk = '0;
        mk.valid = 1'b1;
        mk.btype = t;
        mk.qualifying_predicate = q;
        mk.slot = s;
        mk.ip = 64'h4000;
        mk.ip_rel = (b == 64'h0);
        mk.bundle_displacement_field = d;
        mk.b2 = b;
    endfunction : mk

    // Taken code 2 leaves the taken flag unchecked
    task automatic br(input brx_req_t q, input logic [1:0] t,
                      input logic [63:0] tg);
        @(posedge CLK_I);
        BR_REQ_I <= q;
        @(posedge CLK_I);
        BR_REQ_I <= '0;
        #1 res = BR_RES_O;
        chk(res.valid, 1'b1);
        if (t < 2'd2) chk(res.taken, t[0]);
        if (t == 2'd1) chk(res.target, tg);
    endtask : br

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        rd(8'h30, 64'hffff_ffff);
        rd(8'h38, 64'h4);
        br(mk(BT_COND, 1'b1, 2'h0, 21'h1ffffe, 64'h0), 2'd1, 64'h3fe0);
        br(mk(BT_COND, 1'b0, 2'h0, 21'h4, 64'h0), 2'd0, 64'h0);
        br(mk(BT_COND, 1'b1, 2'h1, 21'h0, 64'h9abc), 2'd1, 64'h9ab0);
        r = mk(BT_COND, 1'b1, 2'h2, 21'h1, 64'h0);
        r.qp_zero = 1'b1;
        r.prefetch_hint_field = 1'b1;
        r.dealloc_hint_field = 1'b1;
        br(r, 2'd1, 64'h4010);
        chk({res.prefetch_hint_field, res.dealloc_hint_field}, 2'b11);
        @(posedge CLK_I);
        GROUP_DONE_I <= 1'b0;
        BR_REQ_I <= mk(BT_COND, 1'b1, 2'h0, 21'h2, 64'h0);
        @(posedge CLK_I);
        BR_REQ_I <= '0;
        @(posedge CLK_I);
        #1 chk({BR_BUSY_O, BR_RES_O.valid}, 2'b10);
        @(posedge CLK_I);
        GROUP_DONE_I <= 1'b1;
        @(posedge CLK_I);
        #1 chk({BR_RES_O.valid, BR_RES_O.target[62:0]}, {1'b1, 63'h4020});
        wr(8'h00, 64'h1);
        br(mk(BT_CLOOP, 1'b0, 2'h2, 21'h4, 64'h0), 2'd1, 64'h4040);
        rd(8'h00, 64'h0);
        br(mk(BT_CLOOP, 1'b1, 2'h2, 21'h4, 64'h0), 2'd0, 64'h0);
        rd(8'h00, 64'h0);
        wr(8'h08, 64'h2);
        br(mk(BT_CTOP, 1'b0, 2'h2, 21'h4, 64'h0), 2'd1, 64'h4040);
        rd(8'h08, 64'h1);
        br(mk(BT_CEXIT, 1'b0, 2'h2, 21'h1, 64'h0), 2'd1, 64'h4010);
        rd(8'h08, 64'h0);
        br(mk(BT_WEXIT, 1'b0, 2'h2, 21'h1, 64'h0), 2'd1, 64'h4010);
        br(mk(BT_WTOP, 1'b0, 2'h2, 21'h4, 64'h0), 2'd0, 64'h0);
        br(mk(BT_WTOP, 1'b1, 2'h2, 21'h4, 64'h0), 2'd1, 64'h4040);
        br(mk(BT_CTOP, 1'b1, 2'h1, 21'h4, 64'h0), 2'd0, 64'h0);
        chk(res.illegal_fault, 1'b1);
        rd(8'h40, 64'h2);
        wr(8'h10, {26'h0, cfm0});
        wr(8'h08, 64'h5);
        br(mk(BT_CALL, 1'b1, 2'h0, 21'h8, 64'h0), 2'd1, 64'h4080);
        chk({res.link_we, res.link[62:0]}, {1'b1, 63'h4010});
        rd(8'h18, {6'h0, 6'h5, 14'h0, cfm0});
        rd(8'h10, 64'h6);
        wr(8'h08, 64'h0);
        br(mk(BT_RET, 1'b1, 2'h0, 21'h0, 64'h8008), 2'd1, 64'h8000);
        rd(8'h10, {26'h0, cfm0});
        rd(8'h08, 64'h5);
        wr(8'h20, 64'h1);
        wr(8'h18, 64'hc000_0000_0000_0000);
        br(mk(BT_RET, 1'b1, 2'h0, 21'h0, 64'h8000), 2'd1, 64'h8000);
        chk(res.lp_trap, 1'b1);
        rd(8'h20, 64'hd);
        wr(8'h18, 64'h0);
        br(mk(BT_RET, 1'b1, 2'h0, 21'h0, 64'h8000), 2'd1, 64'h8000);
        rd(8'h20, 64'hd);
        // Privilege back to 0 so the segment check passes
        wr(8'h20, 64'h0);
        wr(8'h28, 64'h1000);
        // First branch slot, static-taken hint left at its default
        r = mk(BT_IA, 1'b1, 2'h0, 21'h0, 64'hffff_ffff_1234_5678);
        r.qp_zero = 1'b1;
        DIRTY_REGS_I <= 1'b1;
        br(r, 2'd0, 64'h0);
        chk(res.illegal_fault, 1'b1);
        DIRTY_REGS_I <= 1'b0;
        br(r, 2'd1, 64'h1234_4678);
        chk({res.isa_switch, res.alat_ignore}, 2'b11);
        rd(8'h20, 64'h2);
        rd(8'h10, 64'h0);
        chk(RF_HOLD_O, 1'b1);
        FIRST_LEGACY_DONE_I <= 1'b1;
        @(posedge CLK_I);
        FIRST_LEGACY_DONE_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        #1 chk(RF_HOLD_O, 1'b0);
        r.qp_zero = 1'b0;
        br(r, 2'd0, 64'h0);
        chk(res.illegal_fault, 1'b1);
        r.qp_zero = 1'b1;
        wr(8'h30, 64'h100);
        br(r, 2'd2, 64'h0);
        chk(res.general_protection_fault, 1'b1);
        wr(8'h38, 64'hc);
        br(r, 2'd0, 64'h0);
        chk(res.ia_intercept, 1'b1);
        wr(8'h48, 64'h5);
        rd(8'h48, 64'h0);
        stop_test();
    end

    // Whole sequence needs about 120 cycles
    initial begin
        repeat (4000) @(posedge CLK_I);
        failures++;
        stop_test();
    end
endmodule : testbench
